//--- include/mup_map.svh
// Functional notes
// - Reset aborts work, clears status, reinitialises stack pointer; stack may be disturbed.
// - After reset completion flag, error and service request outputs are low.
// - Write strobe pushes a data byte, or enters a command when select high.
// - Read strobe pops a data byte, or returns status when select high.
// - Pause goes low for command-port and data-port accesses alike.
// - Data access waits for a running command; status reads never wait.
// - Idle-device read pause is a few clocks; status read is shorter.
// - Completion flag set at command end; cleared by acknowledge, access or reset.
// - Error output set on failed command; cleared by status read or reset.
`ifndef MUP_MAP_SVH
`define MUP_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MUP_CTRL_OFF      8'h00
`define MUP_STATUS_OFF    8'h04
`define MUP_IRQ_STAT_OFF  8'h08
`define MUP_IRQ_MASK_OFF  8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define MUP_CTRL_CYC_LSB  0
`define MUP_CTRL_ERR_LSB  16
`define MUP_STS_PTR_LSB   8
`define MUP_STS_CMD_LSB   16
`define MUP_STS_END_BIT   24
`define MUP_STS_ERR_BIT   25
`define MUP_STS_SRQ_BIT   26
`define MUP_CMD_SRQ_BIT   7
`define MUP_IRQ_DONE_BIT  0
`define MUP_IRQ_ERR_BIT   1
`define MUP_IRQ_PUSH_BIT  2
`define MUP_IRQ_POP_BIT   3

// ****************************************************************
// Reset values
// ****************************************************************
`define MUP_CTRL_CYC_RST  16'h0010
`define MUP_IRQ_MASK_RST  4'h0
`define MUP_IDLE_CNT_RST  3'h7

// ****************************************************************
// Timing counts in clock periods
// ****************************************************************
`define MUP_POP_CYC       4'h3
`define MUP_STAT_CYC      4'h1
`define MUP_WR_CYC        4'h1
`define MUP_CMD_GAP_CYC   3'h3
`define MUP_DATA_GAP_CYC  3'h4

// ****************************************************************
// Bus answers
// ****************************************************************
`define MUP_RESP_OKAY     2'h0
`define MUP_RESP_SLVERR   2'h2

`endif

//--- include/mup_pkg.sv
`default_nettype none

package mup_pkg;

	typedef enum logic [1:0] {
		MUP_IDLE   = 2'b00,
		MUP_WAIT   = 2'b01,
		MUP_ACCESS = 2'b11,
		MUP_DONE   = 2'b10
	} mup_port_state_t;

	typedef enum logic [1:0] {
		MUP_PUSH = 2'b00,
		MUP_CMD  = 2'b01,
		MUP_POP  = 2'b10,
		MUP_STAT = 2'b11
	} mup_xfer_t;

	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       cmd_sel;
		logic [7:0] db_in;
		logic       completion_ack_n;
		logic       service_ack_n;
	} mup_pin_in_t;

	typedef struct packed {
		logic       pause_n;
		logic [7:0] db_out;
		logic       db_oe;
		logic       completion_flag;
		logic       error_flag;
		logic       service_request;
	} mup_pin_out_t;

	typedef struct packed {
		mup_pin_in_t     sync1;
		mup_pin_in_t     sync2;
		mup_port_state_t pstate;
		mup_xfer_t       xfer;
		logic [3:0]      cnt;
		logic            acted;
		logic [2:0]      idle_cnt;
		logic [3:0]      ptr;
		logic            busy;
		logic [15:0]     exec_cnt;
		logic [7:0]      cmd;
		logic [3:0]      err_code;
		logic [15:0]     ctrl_cycles;
		logic [3:0]      ctrl_err;
		logic [3:0]      irq_stat;
		logic [3:0]      irq_mask;
		logic            irq;
		mup_pin_out_t    pout;
		logic            awready;
		logic            wready;
		logic            aw_got;
		logic            w_got;
		logic [7:0]      awaddr;
		logic [31:0]     wdata;
		logic [3:0]      wstrb;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
	} mup_state_t;

endpackage

`default_nettype wire

//--- verilog/mup_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Operand stack storage
// ****************************************************************
module mup_stack_mem (
	input  wire logic       aclk,
	input  wire logic       we,
	input  wire logic [3:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic       re,
	input  wire logic [3:0] raddr,
	output logic      [7:0] rd_data
);

	logic [7:0] mem_ff [16];
	logic [7:0] rd_data_ff;

	// Contents are not cleared by reset, so the stack may hold stale bytes.
	always_ff @(posedge aclk) begin
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
		if (re) begin
			rd_data_ff <= mem_ff[raddr];
		end
	end

	assign rd_data = rd_data_ff;

endmodule // mup_stack_mem

`default_nettype wire

//--- verilog/mup_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "mup_map.svh"

module mup_host_port (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire mup_pkg::mup_pin_in_t  pin_in,
	output var  mup_pkg::mup_pin_out_t pin_out,
	output logic                       irq,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	import mup_pkg::*;

	mup_state_t  st_ff;
	mup_state_t  nxt;
	mup_pin_in_t s;
	logic        blocked;
	logic        done_evt;
	logic        access_clr;
	logic        stat_clr;
	logic [3:0]  irq_set;
	logic [3:0]  irq_clr;
	logic [31:0] merged;
	logic [31:0] rsel;
	logic [7:0]  status_byte;
	logic        mem_we;
	logic        mem_re;
	logic [3:0]  mem_waddr;
	logic [3:0]  mem_raddr;
	logic [7:0]  mem_rdata;

	// ****************************************************************
	// Operand stack
	// ****************************************************************
	mup_stack_mem u_stack (
		.aclk    (aclk),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (st_ff.sync2.db_in),
		.re      (mem_re),
		.raddr   (mem_raddr),
		.rd_data (mem_rdata)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt         = st_ff;
		s           = st_ff.sync2;
		blocked     = 1'b0;
		access_clr  = 1'b0;
		stat_clr    = 1'b0;
		irq_set     = 4'h0;
		irq_clr     = 4'h0;
		merged      = 32'h0;
		rsel        = 32'h0;
		mem_we      = 1'b0;
		mem_re      = 1'b0;
		mem_waddr   = st_ff.ptr;
		mem_raddr   = st_ff.ptr - 4'h1;
		status_byte = {st_ff.busy, 3'h0, st_ff.err_code};

		// Pins cross into the clock domain through two stages.
		nxt.sync1 = pin_in;
		nxt.sync2 = st_ff.sync1;

		// Write idle time, counted from the release of a write strobe.
		if (st_ff.idle_cnt != 3'h7) begin
			nxt.idle_cnt = st_ff.idle_cnt + 3'h1;
		end

		// Command execution is modelled as a timed busy period.
		done_evt = st_ff.busy && (st_ff.exec_cnt == 16'h0001);
		if (st_ff.busy) begin
			nxt.exec_cnt = st_ff.exec_cnt - 16'h0001;
		end
		if (done_evt) begin
			nxt.busy     = 1'b0;
			nxt.err_code = st_ff.ctrl_err;
			irq_set[`MUP_IRQ_DONE_BIT] = 1'b1;
			irq_set[`MUP_IRQ_ERR_BIT]  = (st_ff.ctrl_err != 4'h0);
		end

		// ****************************************************************
		// Host port sequencer
		// ****************************************************************
		unique case (st_ff.pstate)
			MUP_IDLE: begin
				if (!s.cs_n) begin
					nxt.pstate       = MUP_WAIT;
					nxt.pout.pause_n = 1'b0;
				end
			end
			MUP_WAIT: begin
				if (s.cs_n) begin
					nxt.pstate       = MUP_IDLE;
					nxt.pout.pause_n = 1'b1;
				end else if (!s.rd_n) begin
					nxt.xfer   = s.cmd_sel ? MUP_STAT : MUP_POP;
					nxt.cnt    = s.cmd_sel ? `MUP_STAT_CYC : `MUP_POP_CYC;
					nxt.pstate = MUP_ACCESS;
					access_clr = 1'b1;
				end else if (!s.wr_n) begin
					nxt.xfer   = s.cmd_sel ? MUP_CMD : MUP_PUSH;
					nxt.cnt    = `MUP_WR_CYC;
					nxt.pstate = MUP_ACCESS;
				end
			end
			MUP_ACCESS: begin
				// Status reads bypass the wait on a running command.
				blocked = ((st_ff.xfer != MUP_STAT) && st_ff.busy) ||
					((st_ff.xfer == MUP_CMD) && (st_ff.idle_cnt < `MUP_CMD_GAP_CYC)) ||
					((st_ff.xfer == MUP_PUSH) && (st_ff.idle_cnt < `MUP_DATA_GAP_CYC));
				if (!blocked) begin
					if ((st_ff.xfer == MUP_POP) && !st_ff.acted) begin
						mem_re    = 1'b1;
						nxt.ptr   = st_ff.ptr - 4'h1;
						nxt.acted = 1'b1;
					end
					if (st_ff.cnt == 4'h1) begin
						nxt.pstate       = MUP_DONE;
						nxt.pout.pause_n = 1'b1;
						nxt.acted        = 1'b0;
						unique case (st_ff.xfer)
							MUP_PUSH: begin
								mem_we  = 1'b1;
								nxt.ptr = st_ff.ptr + 4'h1;
								irq_set[`MUP_IRQ_PUSH_BIT] = 1'b1;
							end
							MUP_CMD: begin
								nxt.busy     = 1'b1;
								nxt.cmd      = s.db_in;
								nxt.err_code = 4'h0;
								nxt.exec_cnt = (st_ff.ctrl_cycles == 16'h0) ? 16'h0001 :
									st_ff.ctrl_cycles;
							end
							MUP_POP: begin
								nxt.pout.db_out = mem_rdata;
								nxt.pout.db_oe  = 1'b1;
								irq_set[`MUP_IRQ_POP_BIT] = 1'b1;
							end
							MUP_STAT: begin
								nxt.pout.db_out = status_byte;
								nxt.pout.db_oe  = 1'b1;
								stat_clr        = 1'b1;
							end
						endcase
					end else begin
						nxt.cnt = st_ff.cnt - 4'h1;
					end
				end
			end
			MUP_DONE: begin
				// Data stays on the bus for as long as the read strobe is held.
				if (s.rd_n && s.wr_n) begin
					nxt.pout.db_oe = 1'b0;
					if ((st_ff.xfer == MUP_PUSH) || (st_ff.xfer == MUP_CMD)) begin
						access_clr   = 1'b1;
						nxt.idle_cnt = 3'h0;
					end
					if (s.cs_n) begin
						nxt.pstate = MUP_IDLE;
					end else begin
						nxt.pstate       = MUP_WAIT;
						nxt.pout.pause_n = 1'b0;
					end
				end
			end
		endcase

		// ****************************************************************
		// Host-visible flags; a set in the same cycle beats a clear
		// ****************************************************************
		if (!s.completion_ack_n || access_clr) begin
			nxt.pout.completion_flag = 1'b0;
		end
		if (done_evt) begin
			nxt.pout.completion_flag = 1'b1;
		end
		if (stat_clr) begin
			nxt.pout.error_flag = 1'b0;
		end
		if (done_evt && (st_ff.ctrl_err != 4'h0)) begin
			nxt.pout.error_flag = 1'b1;
		end
		// A held-low acknowledge fights the set, so the request may be missed.
		if (!s.service_ack_n) begin
			nxt.pout.service_request = 1'b0;
		end
		if (done_evt) begin
			nxt.pout.service_request = st_ff.cmd[`MUP_CMD_SRQ_BIT];
		end

		// ****************************************************************
		// AXI4-Lite write channel
		// ****************************************************************
		if (s_axi_awvalid && st_ff.awready) begin
			nxt.aw_got  = 1'b1;
			nxt.awready = 1'b0;
			nxt.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt.w_got  = 1'b1;
			nxt.wready = 1'b0;
			nxt.wdata  = s_axi_wdata;
			nxt.wstrb  = s_axi_wstrb;
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt.aw_got = 1'b0;
			nxt.w_got  = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp  = `MUP_RESP_OKAY;
			merged = {12'h0, st_ff.ctrl_err, st_ff.ctrl_cycles};
			for (int i = 0; i < 4; i++) begin
				if (st_ff.wstrb[i]) begin
					merged[i*8 +: 8] = st_ff.wdata[i*8 +: 8];
				end
			end
			unique case ({st_ff.awaddr[7:2], 2'b00})
				`MUP_CTRL_OFF: begin
					nxt.ctrl_cycles = merged[`MUP_CTRL_CYC_LSB +: 16];
					nxt.ctrl_err    = merged[`MUP_CTRL_ERR_LSB +: 4];
				end
				`MUP_STATUS_OFF: begin
				end
				`MUP_IRQ_STAT_OFF: begin
					if (st_ff.wstrb[0]) begin
						irq_clr = st_ff.wdata[3:0];
					end
				end
				`MUP_IRQ_MASK_OFF: begin
					if (st_ff.wstrb[0]) begin
						nxt.irq_mask = st_ff.wdata[3:0];
					end
				end
				default: begin
					nxt.bresp = `MUP_RESP_SLVERR;
				end
			endcase
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt.bvalid  = 1'b0;
			nxt.awready = 1'b1;
			nxt.wready  = 1'b1;
		end

		// ****************************************************************
		// AXI4-Lite read channel
		// ****************************************************************
		if (s_axi_arvalid && st_ff.arready) begin
			nxt.arready = 1'b0;
			nxt.rvalid  = 1'b1;
			nxt.rresp   = `MUP_RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				`MUP_CTRL_OFF: begin
					rsel = {12'h0, st_ff.ctrl_err, st_ff.ctrl_cycles};
				end
				`MUP_STATUS_OFF: begin
					rsel[7:0]                    = status_byte;
					rsel[`MUP_STS_PTR_LSB +: 4]  = st_ff.ptr;
					rsel[`MUP_STS_CMD_LSB +: 8]  = st_ff.cmd;
					rsel[`MUP_STS_END_BIT]       = st_ff.pout.completion_flag;
					rsel[`MUP_STS_ERR_BIT]       = st_ff.pout.error_flag;
					rsel[`MUP_STS_SRQ_BIT]       = st_ff.pout.service_request;
				end
				`MUP_IRQ_STAT_OFF: begin
					rsel[3:0] = st_ff.irq_stat;
				end
				`MUP_IRQ_MASK_OFF: begin
					rsel[3:0] = st_ff.irq_mask;
				end
				default: begin
					nxt.rresp = `MUP_RESP_SLVERR;
				end
			endcase
			nxt.rdata = rsel;
		end
		if (st_ff.rvalid && s_axi_rready) begin
			nxt.rvalid  = 1'b0;
			nxt.arready = 1'b1;
		end

		// Sticky events: a new event outlives a write-one-to-clear in the same cycle.
		nxt.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_set;
		nxt.irq      = |(nxt.irq_stat & nxt.irq_mask);
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff                  <= '0;
			st_ff.sync1            <= '1;
			st_ff.sync2            <= '1;
			st_ff.idle_cnt         <= `MUP_IDLE_CNT_RST;
			st_ff.ctrl_cycles      <= `MUP_CTRL_CYC_RST;
			st_ff.irq_mask         <= `MUP_IRQ_MASK_RST;
			st_ff.pout.pause_n     <= 1'b1;
			st_ff.awready          <= 1'b1;
			st_ff.wready           <= 1'b1;
			st_ff.arready          <= 1'b1;
		end else begin
			st_ff <= nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign pin_out       = st_ff.pout;
	assign irq           = st_ff.irq;
	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready  = st_ff.wready;
	assign s_axi_bvalid  = st_ff.bvalid;
	assign s_axi_bresp   = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid  = st_ff.rvalid;
	assign s_axi_rdata   = st_ff.rdata;
	assign s_axi_rresp   = st_ff.rresp;

endmodule // mup_host_port

`default_nettype wire

//--- sim/mup_host_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module mup_host_port_monitor (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire mup_pkg::mup_pin_in_t  pin_in,
	input wire mup_pkg::mup_pin_out_t pin_out,
	input wire logic                  irq,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [1:0]            s_axi_bresp
);
	import mup_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_quiet: assert property (disable iff (1'b0)
		!aresetn |=> pin_out.pause_n && !pin_out.completion_flag && !pin_out.error_flag
		&& !pin_out.service_request && !irq) else $error("outputs not idle after reset");
	a_pause_cs: assert property (
		$fell(pin_in.cs_n) && pin_in.rd_n && pin_in.wr_n |-> ##[1:4] !pin_out.pause_n)
		else $error("pause_n did not fall after select");
	a_stat_fast: assert property (
		$fell(pin_in.rd_n) && pin_in.cmd_sel && !pin_in.cs_n |-> ##[1:5] pin_out.pause_n)
		else $error("status read was held");
	a_pop_time: assert property (
		$fell(pin_in.rd_n) && !pin_in.cmd_sel && !pin_in.cs_n |=> !pin_out.pause_n [*4])
		else $error("data pop released too early");
	a_read_data: assert property (
		$rose(pin_out.db_oe) |-> $rose(pin_out.pause_n) && !pin_in.rd_n)
		else $error("bus driven outside a read");
	a_err_clear: assert property (
		$fell(pin_out.error_flag) |-> pin_out.db_oe || !$past(aresetn))
		else $error("error flag cleared without status read");
	// A write clears the flag only after its release has crossed the synchroniser.
	a_end_clear: assert property (
		$fell(pin_out.completion_flag) |-> !$past(aresetn) || !$past(pin_in.cs_n, 4)
		|| !$past(pin_in.completion_ack_n, 2)) else $error("completion flag lost");
	a_srq_end: assert property (
		$rose(pin_out.service_request) |-> pin_out.completion_flag)
		else $error("service request without completion");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_b_hold: assert property (s_axi_bvalid |=> ($past(s_axi_bready) ? !s_axi_bvalid
		: (s_axi_bvalid && $stable(s_axi_bresp)))) else $error("write answer not held");
endmodule // mup_host_port_monitor

bind mup_host_port mup_host_port_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
	.pin_in(pin_in), .pin_out(pin_out), .irq(irq), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));
`default_nettype wire

//--- sim/mup_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host processor model
// ****************************************************************
module mup_host_model (
	input  wire logic                  aclk,
	input  wire mup_pkg::mup_pin_out_t pin_out,
	output var mup_pkg::mup_pin_in_t   pin_in
);
	import mup_pkg::*;
	int lost = 0;
	initial pin_in = mup_pin_in_t'(14'h3803);
	task automatic xfer(input logic rd, input logic sel, input logic [7:0] wd,
		output logic [7:0] rv, output int n);
		int t;
		@(posedge aclk);
		pin_in.cs_n <= 1'b0;
		pin_in.cmd_sel <= sel;
		if (!rd)
			pin_in.db_in <= wd;
		t = 0;
		do begin
			@(posedge aclk);
			t++;
		end while (pin_out.pause_n !== 1'b0 && t < 20);
		if (pin_out.pause_n !== 1'b0)
			lost++;
		if (rd)
			pin_in.rd_n <= 1'b0;
		else
			pin_in.wr_n <= 1'b0;
		n = 0;
		// The strobe stays down until pause releases, for at most 3000 clocks.
		do begin
			@(posedge aclk);
			n++;
		end while (pin_out.pause_n !== 1'b1 && n < 3000);
		if (pin_out.pause_n !== 1'b1)
			lost++;
		rv = pin_out.db_out;
		pin_in.rd_n <= 1'b1;
		pin_in.wr_n <= 1'b1;
		pin_in.cs_n <= 1'b1;
		// A released bus must not keep showing the last byte.
		pin_in.db_in <= ~pin_in.db_in;
		repeat (5) @(posedge aclk);
	endtask
	task automatic ack();
		@(posedge aclk);
		pin_in.completion_ack_n <= 1'b0;
		pin_in.service_ack_n <= 1'b0;
		repeat (4) @(posedge aclk);
		pin_in.completion_ack_n <= 1'b1;
		pin_in.service_ack_n <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask
endmodule // mup_host_model
`default_nettype wire

//--- sim/tb_mup_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "mup_map.svh"
// ****************************************************************
// Testbench
// ****************************************************************
module tb_mup_host_port;
	import mup_pkg::*;
	logic         aclk;
	logic         aresetn;
	mup_pin_in_t  pin_in;
	mup_pin_out_t pin_out;
	logic         irq;
	logic [7:0]   awaddr;
	logic [7:0]   araddr;
	logic [31:0]  wdata;
	logic [31:0]  rdata;
	logic [1:0]   bresp;
	logic [1:0]   rresp;
	logic         awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready;
	int           errors;
	int           checks_done;

	mup_host_port uut (.aclk(aclk), .aresetn(aresetn), .pin_in(pin_in), .pin_out(pin_out),
		.irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	mup_host_model host (.aclk(aclk), .pin_out(pin_out), .pin_in(pin_in));

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int t;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		t = 0;
		do begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			t++;
		end while (bvalid !== 1'b1 && t < 50);
		chk("wr_answer", bvalid, 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 0;
		do begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			t++;
		end while (rvalid !== 1'b1 && t < 50);
		chk("rd_answer", rvalid, 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		chk(nm, d, e);
	endtask
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	task automatic t_reset();
		chk("rst_pins", {pin_out.pause_n, pin_out.db_oe, pin_out.completion_flag,
			pin_out.error_flag, pin_out.service_request, irq}, 6'b100000);
		rchk("ctrl", `MUP_CTRL_OFF, 32'h0000_0010);
		rchk("mask", `MUP_IRQ_MASK_OFF, 32'h0);
		rchk("status", `MUP_STATUS_OFF, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_stack();
		logic [7:0]  v;
		logic [1:0]  r;
		int          n;
		for (int i = 0; i < 4; i++) begin
			host.xfer(1'b0, 1'b0, 8'(8'h11 * (i + 1)), v, n);
			if (i == 0)
				chk("push_wait", n, 5);
		end
		rchk("ptr", `MUP_STATUS_OFF, 32'h0000_0400);
		for (int i = 4; i > 0; i--) begin
			host.xfer(1'b1, 1'b0, 8'h00, v, n);
			chk("pop", v, 8'(8'h11 * i));
			chk("pop_wait", n, 7);
		end
		rchk("irq_stat", `MUP_IRQ_STAT_OFF, 32'hc);
		axi_wr(`MUP_IRQ_STAT_OFF, 32'hf, r);
		rchk("irq_w1c", `MUP_IRQ_STAT_OFF, 32'h0);
		$display("t_stack done");
	endtask
	task automatic t_cmd();
		logic [7:0]  v;
		logic [1:0]  r;
		int          n;
		axi_wr(`MUP_CTRL_OFF, 32'h0000_0020, r);
		host.xfer(1'b0, 1'b1, 8'h85, v, n);
		chk("cmd_wait", n, 5);
		host.xfer(1'b1, 1'b1, 8'h00, v, n);
		chk("stat_wait", n, 5);
		chk("stat_busy", v, 8'h80);
		n = 0;
		while (pin_out.completion_flag !== 1'b1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		chk("end_flags", {pin_out.completion_flag, pin_out.error_flag,
			pin_out.service_request, irq}, 4'b1010);
		axi_wr(`MUP_IRQ_MASK_OFF, 32'h1, r);
		repeat (2) @(posedge aclk);
		chk("irq_on", irq, 1);
		axi_wr(`MUP_IRQ_STAT_OFF, 32'h1, r);
		repeat (2) @(posedge aclk);
		chk("irq_off", irq, 0);
		host.ack();
		chk("ack", {pin_out.completion_flag, pin_out.service_request}, 2'b00);
		$display("t_cmd done");
	endtask
	task automatic t_err();
		logic [7:0]  v;
		logic [1:0]  r;
		int          n;
		axi_wr(`MUP_CTRL_OFF, 32'h0003_0020, r);
		host.xfer(1'b0, 1'b1, 8'h05, v, n);
		host.xfer(1'b0, 1'b0, 8'h5a, v, n);
		chk("busy_wait", n > 10, 1);
		chk("err_flags", {pin_out.completion_flag, pin_out.error_flag,
			pin_out.service_request}, 3'b010);
		host.xfer(1'b1, 1'b1, 8'h00, v, n);
		chk("err_code", v, 8'h03);
		chk("err_clr", pin_out.error_flag, 0);
		// The pushed byte leaves the pointer at one, so a zero read proves the reinit.
		do_reset();
		rchk("ptr_rst", `MUP_STATUS_OFF, 32'h0);
		$display("t_err done");
	endtask
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(8'h10, d, r);
		chk("rd_resp", r, `MUP_RESP_SLVERR);
		axi_wr(8'h10, 32'h1, r);
		chk("wr_resp", r, `MUP_RESP_SLVERR);
		$display("t_bus done");
	endtask
	task automatic test_done();
		// Host waits that ran out of time count as mismatches.
		errors += host.lost;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		test_done();
	end
	initial begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		errors = 0;
		checks_done = 0;
		do_reset();
		t_reset();
		t_stack();
		t_cmd();
		t_err();
		t_bus();
		test_done();
	end
endmodule // tb_mup_host_port
`default_nettype wire
